/* dv/dacc_pins_model.sv */
// pin side partner: capture levels, count inputs, external overflow
// assumes the bench sets the levels and requests just after an edge
`timescale 1ns/1ns
module dacc_pins_model
    import dacc_pkg::*;
#(
    parameter int CH = NUM_CH
)
(
    input  wire logic [CH-1:0] cc_pin_out,
    input  wire logic [CH-1:0] cc_pin_oe,
    input  wire logic [CH-1:0] lvl,
    input  wire logic          hclk,
    input  wire logic          ovf_req,
    input  wire logic [1:0]    cnt_lvl,
    output logic [CH-1:0]      cc_pin_in,
    output logic [1:0]         count_in,
    output logic               ext_gp_ovf = 1'b0
);
    // ************
    // pin wires
    // ************
    // a driven pin reads back its own drive, else the outside level
    assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & lvl);
    assign count_in  = cnt_lvl;
    // overflow from a timer on the same clock: one-cycle pulse
    always @(posedge hclk) begin
        ext_gp_ovf <= ovf_req;
    end
endmodule

/* dv/dacc_top_sva.sv */
// checker: bus answer, pin drive and interrupt mask relations
// assumes it is bound into each dacc_top and sees only its ports
`timescale 1ns/1ns
module dacc_top_sva
    import dacc_pkg::*;
#(
    parameter int CH = NUM_CH
)
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [11:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic [31:0]   hrdata,
    input wire logic [CH-1:0] cc_pin_out,
    input wire logic [CH-1:0] cc_pin_oe,
    input wire logic          irq
);
    // ************
    // data phase
    // ************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        a_q;
    logic        w_q;
    logic [11:0] ad_q;
    // address phase taken at the last edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_q  <= 1'b0;
            w_q  <= 1'b0;
            ad_q <= 12'h000;
        end else begin
            a_q  <= hsel && htrans[1] && hready;
            w_q  <= hwrite;
            ad_q <= haddr;
        end
    end
    // ************
    // assertions
    // ************
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    rdata_hold_a: assert property
        (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    value_upper_a: assert property (a_q && !w_q && (ad_q[11:5] == 7'h01
        || ad_q[11:7] == 5'h03) |-> hrdata[31:16] == 16'h0000)
        else $error("upper half of a 16-bit value not zero");
    unmap_zero_a: assert property (a_q && !w_q && ad_q[11:8] == 4'h0
        && ad_q[7:6] != 2'h0 |-> hrdata == WORD_RST)
        else $error("unmapped read not zero");
    oe_cause_a: assert property
        ($changed(cc_pin_oe) |-> $past(a_q && w_q))
        else $error("pin enable changed without a write");
    pin_quiet_a: assert property (((cc_pin_out ^ $past(cc_pin_out))
        & ~cc_pin_oe & ~$past(cc_pin_oe)) == '0)
        else $error("undriven pin value changed");
    mask_clear_a: assert property (a_q && w_q && ad_q == ADDR_IRQ_MSK
        && hwdata == WORD_RST |=> !irq)
        else $error("irq high with all masked");
    cover property ($rose(irq));
    cover property ($changed(cc_pin_out));
    cover property (a_q && !w_q);
endmodule

bind dacc_top dacc_top_sva #(.CH(CH)) dacc_top_sva_inst (.*);

/* dv/dual_array_capture_compare_test.sv */
// bench: ahb master, pin partner, queued read data checks
// assumes a zero-wait dacc_top slave and the pin model beside it
`timescale 1ns/1ns
module dual_array_capture_compare_test
    import dacc_pkg::*;
;
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic              hwrite = 1'b0, ovf_req = 1'b0, rp = 1'b0;
    logic              cen = 1'b0, hreadyout, hresp, irq, ext_ovf;
    logic [11:0]       haddr = 12'h000;
    logic [1:0]        htrans = 2'h0, cnt_lvl = 2'h0, cnt_in;
    logic [31:0]       hwdata = 32'h0, hrdata, q[$];
    logic [NUM_CH-1:0] lvl = '0, pin_in, pin_out, pin_oe, p_q;
    logic [15:0]       v1, v2;
    int fail_count = 0, n_compared = 0, seed = 32'h3eaa, k, c;
    int tg0 = 0, rs3 = 0, tg5 = 0, cc[5] = '{0, 3, 5, 4, 6};
    logic [31:0] cm[5] = '{5, 7, 21, 6, 4};
    logic [31:0] cv[5] = '{'hfff5, 'hfff8, 'hfff2, 'hfff3, 'hfff3};
    always #5 hclk = ~hclk;
    dacc_top dacc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_gp_ovf(ext_ovf),
        .count_in(cnt_in), .cc_pin_in(pin_in), .cc_pin_out(pin_out),
        .cc_pin_oe(pin_oe), .irq(irq));
    dacc_pins_model dacc_pins_model_inst (.hclk(hclk), .lvl(lvl),
        .cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .cnt_lvl(cnt_lvl),
        .ovf_req(ovf_req), .cc_pin_in(pin_in), .count_in(cnt_in),
        .ext_gp_ovf(ext_ovf));
    // ************
    // tasks
    // ************
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for hready at a rising edge
    task automatic wt();
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic w = 1'b1);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask
    // the expected word is noted before the read goes out
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        wr(a, 32'h0, 1'b0);
    endtask
    task automatic setv(input logic [15:0] v);
        wr(ADDR_TVAL, {16'h0, v});
        wr(ADDR_TVAL + 12'h008, {16'h0, v});
    endtask
    // monitor: read data against the oldest note; pin edge counts
    always @(posedge hclk) begin
        if (rp) chk("hrdata", q.pop_front(), hrdata);
        rp <= hsel && htrans[1] && !hwrite && hreadyout;
        p_q <= pin_out;
        tg0 += int'(cen && pin_out[0] !== p_q[0]);
        rs3 += int'(cen && pin_out[3] && !p_q[3]);
        tg5 += int'(cen && pin_out[5] !== p_q[5]);
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_IRQ_ST, WORD_RST);
        wr(12'h0fc, 32'hffff_ffff);
        rd(12'h0fc, WORD_RST);
        // rise, fall, both: timers stopped, so values are exact
        for (int i = 1; i <= 3; i++) begin
            c = (i == 3) ? 19 : i;
            v1 = 16'($random(seed));
            setv(v1);
            wr(ADDR_CCFG + 12'(4 * c), 32'(i));
            lvl[c] <= 1'b1;
            repeat (8) @(posedge hclk);
            rd(ADDR_CVAL + 12'(4 * c), i == 2 ? WORD_RST : {16'h0, v1});
            v2 = 16'($random(seed));
            setv(v2);
            lvl[c] <= 1'b0;
            repeat (8) @(posedge hclk);
            rd(ADDR_CVAL + 12'(4 * c), {16'h0, i == 1 ? v1 : v2});
        end
        wr(ADDR_IRQ_MSK, 32'h2);
        #1 chk("irq", 32'h1, {31'h0, irq});
        rd(ADDR_IRQ_ST, 32'h0008_0006);
        rd(ADDR_IRQ_ST, WORD_RST);
        wr(ADDR_IRQ_MSK, WORD_RST);
        // every compare mode on timer 0 with a 16-step period
        setv(16'hfff0);
        wr(ADDR_TRLD, 32'hfff0);
        foreach (cc[j]) begin
            wr(ADDR_CVAL + 12'(4 * cc[j]), cv[j]);
            wr(ADDR_CCFG + 12'(4 * cc[j]), cm[j]);
        end
        wr(ADDR_TCFG, 32'h100);
        cen <= 1'b1;
        repeat (64) @(posedge hclk);
        cen <= 1'b0;
        wr(ADDR_TCFG, WORD_RST);
        chk("toggles", 32'h4, 32'(tg0));
        chk("rises", 32'h4, 32'(rs3));
        chk("single", 32'h1, 32'(tg5));
        rd(ADDR_IRQ_ST, 32'h0000_0079);
        // count input and external overflow as timer clocks
        wr(ADDR_TVAL, WORD_RST);
        wr(ADDR_TCFG, 32'h120);
        wr(ADDR_TCFG + 12'h008, 32'h110);
        repeat (3) begin
            ovf_req <= 1'b1;
            cnt_lvl <= 2'h1;
            @(posedge hclk);
            ovf_req <= 1'b0;
            repeat (8) @(posedge hclk);
            cnt_lvl <= 2'h0;
            repeat (8) @(posedge hclk);
        end
        rd(ADDR_TVAL, 32'h3);
        rd(ADDR_TVAL + 12'h008, 32'hfff3);
        // staggered: 80 run edges give exactly ten steps
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_TVAL, WORD_RST);
        wr(ADDR_TCFG, 32'h100);
        repeat (77) @(posedge hclk);
        wr(ADDR_TCFG, WORD_RST);
        rd(ADDR_TVAL, 32'ha);
        close_out();
    end
endmodule

/* include/dacc_pkg.sv */
// dual-array capture/compare: shared constants, register map and types
// assumes a 32-bit ahb-lite slave port and one 100 MHz clock
package dacc_pkg;

    // ************
    // sizes
    // ************
    localparam int NUM_CH     = 32;
    localparam int NUM_TMR    = 4;
    localparam int TMR_W      = 16;
    localparam int PSC_W      = 11;
    localparam int SYNC_N     = 34;

    // ************
    // register byte addresses (word aligned)
    // ************
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_IRQ_ST  = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MSK = 12'h008;
    localparam logic [11:0] ADDR_TCFG    = 12'h010;
    localparam logic [11:0] ADDR_TVAL    = 12'h020;
    localparam logic [11:0] ADDR_TRLD    = 12'h030;
    localparam logic [11:0] ADDR_CCFG    = 12'h100;
    localparam logic [11:0] ADDR_CVAL    = 12'h180;

    // ************
    // field positions and reset values
    // ************
    localparam int CTRL_STAGGER_BIT = 0;
    localparam int TCFG_PSC_LSB     = 0;
    localparam int TCFG_SRC_LSB     = 4;
    localparam int TCFG_RUN_BIT     = 8;
    localparam int CCFG_MODE_LSB    = 0;
    localparam int CCFG_TSEL_BIT    = 3;
    localparam int CCFG_SINGLE_BIT  = 4;
    localparam int CCFG_DOUBLE_BIT  = 5;
    localparam logic [TMR_W-1:0] TMR_RST  = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_MAX  = 16'hffff;
    localparam logic [31:0]      WORD_RST = 32'h0000_0000;
    localparam logic [2:0]       STAG_SLOTS_M1 = 3'h7;

    // ************
    // timer clock sources
    // ************
    localparam logic [1:0] SRC_PRESCALE = 2'h0;
    localparam logic [1:0] SRC_EXT_OVF  = 2'h1;
    localparam logic [1:0] SRC_COUNT_IN = 2'h2;

    // ************
    // channel modes
    // ************
    typedef enum logic [2:0] {
        DACC_OFF      = 3'h0,
        DACC_CAP_RISE = 3'h1,
        DACC_CAP_FALL = 3'h2,
        DACC_CAP_BOTH = 3'h3,
        DACC_CMP0     = 3'h4,
        DACC_CMP1     = 3'h5,
        DACC_CMP2     = 3'h6,
        DACC_CMP3     = 3'h7
    } dacc_mode_t;

    // per-channel configuration
    typedef struct packed {
        logic       dbl;
        logic       single;
        logic       tsel;
        dacc_mode_t mode;
    } dacc_ccfg_t;

    // per-timer configuration
    typedef struct packed {
        logic       run;
        logic [1:0] src;
        logic [2:0] psc;
    } dacc_tcfg_t;

    // time base as seen by a channel
    typedef struct packed {
        logic [TMR_W-1:0] value;
        logic             strobe;
        logic             ovf;
    } dacc_tbase_t;

endpackage

/* rtl/dacc_channel.sv */
// one capture/compare channel: value register, match and pin logic
// assumes its time base strobe follows each timer step by one cycle
`timescale 1ns/1ns
module dacc_channel
    import dacc_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire dacc_ccfg_t       cfg,
    input  wire logic             cfg_wr,
    input  wire logic             val_wr,
    input  wire logic [TMR_W-1:0] wdata,
    input  wire dacc_tbase_t      tb,
    input  wire logic             pin_rise,
    input  wire logic             pin_fall,
    input  wire logic             partner_match,
    output logic [TMR_W-1:0]      val_q,
    output logic                  pin_out_q,
    output logic                  pin_oe,
    output logic                  match,
    output logic                  irq_ev
);

    logic armed_q;
    logic done_q;
    logic is_cmp;
    logic multi;
    logic cap_ev;

    // ************************************************************
    // event detection
    // ************************************************************
    assign is_cmp = cfg.mode[2];
    assign multi  = (cfg.mode == DACC_CMP0) || (cfg.mode == DACC_CMP1);
    // continuous equality check on each new timer value [RQ16]
    assign match  = is_cmp && tb.strobe && !done_q &&
                    (tb.value == val_q) && (multi || armed_q); // [RQ7] [RQ9]
    // selectable capture edge [RQ15]
    assign cap_ev = ((cfg.mode == DACC_CAP_RISE) && pin_rise) ||
                    ((cfg.mode == DACC_CAP_FALL) && pin_fall) ||
                    ((cfg.mode == DACC_CAP_BOTH) && (pin_rise || pin_fall));
    // every capture and every compare hit asks for service [RQ14]
    assign irq_ev = cap_ev || match;
    // pin is driven only in the pin-action modes [RQ6]
    assign pin_oe = (cfg.mode == DACC_CMP1) || (cfg.mode == DACC_CMP3);

    // value register: a capture beats a software write [RQ13]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val_q <= TMR_RST;
        end else if (cap_ev) begin
            val_q <= tb.value;
        end else if (val_wr) begin
            val_q <= wdata;
        end
    end

    // once-per-period arming, rearmed by the timer overflow [RQ9] [RQ10]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 1'b1;
        end else if (match) begin
            armed_q <= 1'b0;
        end else if (tb.ovf || cfg_wr) begin
            armed_q <= 1'b1;
        end
    end

    // single event: lock after the first hit until reconfigured [RQ12]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else if (match && cfg.single) begin
            done_q <= 1'b1;
        end else if (cfg_wr) begin
            done_q <= 1'b0;
        end
    end

    // pin actions; a set wins over the overflow clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_q <= 1'b0;
        end else if (cfg.mode == DACC_CMP1) begin
            if (match != (cfg.dbl && partner_match)) begin
                pin_out_q <= !pin_out_q; // [RQ8] [RQ11]
            end
        end else if (cfg.mode == DACC_CMP3) begin
            if (match) begin
                pin_out_q <= 1'b1; // [RQ10]
            end else if (tb.ovf) begin
                pin_out_q <= 1'b0; // [RQ10]
            end
        end
    end

endmodule

/* rtl/dacc_top.sv */
// dual-array capture/compare unit: bus slave, time bases, 32 channels
// assumes one 100 MHz clock; pins and count inputs are asynchronous,
// the external timer overflow pulse comes from logic on the same clock
//
// Functional notes
// RQ1: 32 channels, one-cycle resolution, eight cycles when staggered.
// RQ2: each array has two 16-bit timers, each with its reload register.
// RQ3: timers clock from a prescaled system clock or external overflow.
// RQ4: first timer of each array may count an external count input.
// RQ5: 16 registers per array, each picks a timer and capture or compare.
// RQ6: each register owns a pin: capture input or compare output.
// RQ7: compare mode 0 raises interrupts only, several per period.
// RQ8: compare mode 1 toggles the pin on every match.
// RQ9: compare mode 2 raises interrupts only, at most one per period.
// RQ10: compare mode 3 sets the pin on match, clears it on overflow.
// RQ11: double register mode lets two registers toggle one pin.
// RQ12: single-event option yields one edge or pulse, any compare mode.
// RQ13: a capture copies the selected timer value into the register.
// RQ14: each capture raises that register's own interrupt request.
// RQ15: capture edge selectable: rising, falling or both.
// RQ16: compare registers are checked against their timer continuously.
// RQ17: a timer reloads from its reload register on overflow.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module dacc_top
    import dacc_pkg::*;
#(
    parameter int CH = NUM_CH
)
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [11:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    input  wire logic          ext_gp_ovf,
    input  wire logic [1:0]    count_in,
    input  wire logic [CH-1:0] cc_pin_in,
    output logic [CH-1:0]      cc_pin_out,
    output logic [CH-1:0]      cc_pin_oe,
    output logic               irq
);

    // ************
    // declarations
    // ************
    logic                       stagger_q;
    logic [CH-1:0]              irq_st_q;
    logic [CH-1:0]              irq_msk_q;
    dacc_tcfg_t                 tcfg_q   [NUM_TMR];
    logic [TMR_W-1:0]           tval_q   [NUM_TMR];
    logic [TMR_W-1:0]           trld_q   [NUM_TMR];
    logic [NUM_TMR-1:0]         tstep;
    logic [NUM_TMR-1:0]         tstrobe_q;
    logic [NUM_TMR-1:0]         tovf_q;
    dacc_ccfg_t                 ccfg_q   [CH];
    logic [TMR_W-1:0]           cval     [CH];
    logic [CH-1:0]              cmatch;
    logic [CH-1:0]              cirq_ev;
    logic [PSC_W-1:0]           psc_q;
    logic [7:0]                 psc_eff;
    logic                       base_en;
    logic [SYNC_N-1:0]          s1_q;
    logic [SYNC_N-1:0]          s2_q;
    logic [SYNC_N-1:0]          s3_q;
    logic [SYNC_N-1:0]          stable_q;
    logic [SYNC_N-1:0]          rise;
    logic [SYNC_N-1:0]          fall;
    logic                       wr_pend_q;
    logic [11:0]                wr_addr_q;
    logic                       rd_go;
    logic                       wr_go;
    logic [31:0]                rd_word;
    logic [CH-1:0]              st_clr;
    logic                       st_read;

    // ************
    // ahb-lite slave
    // ************
    // zero wait states, so the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_go     = hsel && hready && htrans[1] && !hwrite;
    assign wr_go     = hsel && hready && htrans[1] && hwrite;

    // write address phase is held until its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else if (hready) begin
            wr_pend_q <= wr_go;
            wr_addr_q <= haddr;
        end
    end

    // read word chosen at the address phase; haddr[11:9] is not decoded, so reads there alias the map; other unmapped reads give zero
    always_comb begin
        rd_word = WORD_RST;
        st_read = 1'b0;
        if (haddr[8]) begin
            if (!haddr[7]) begin
                rd_word = {26'h0, ccfg_q[haddr[6:2]]};
            end else begin
                rd_word = {16'h0, cval[haddr[6:2]]};
            end
        end else begin
            unique case (haddr[7:4])
                4'h0: begin
                    if (haddr[3:0] == ADDR_CTRL[3:0]) begin
                        rd_word = {31'h0, stagger_q};
                    end else if (haddr[3:0] == ADDR_IRQ_ST[3:0]) begin
                        rd_word = irq_st_q;
                        st_read = 1'b1;
                    end else if (haddr[3:0] == ADDR_IRQ_MSK[3:0]) begin
                        rd_word = irq_msk_q;
                    end
                end
                4'h1: rd_word = {23'h0, tcfg_q[haddr[3:2]].run, 2'h0,
                                 tcfg_q[haddr[3:2]].src, 1'b0,
                                 tcfg_q[haddr[3:2]].psc};
                4'h2: rd_word = {16'h0, tval_q[haddr[3:2]]};
                4'h3: rd_word = {16'h0, trld_q[haddr[3:2]]};
                default: rd_word = WORD_RST;
            endcase
        end
    end

    // read data registered so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_RST;
        end else if (rd_go) begin
            hrdata <= rd_word;
        end
    end

    // control and mask registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stagger_q <= 1'b0;
            irq_msk_q <= '0;
        end else if (wr_pend_q) begin
            if (wr_addr_q == ADDR_CTRL) begin
                stagger_q <= hwdata[CTRL_STAGGER_BIT];
            end
            if (wr_addr_q == ADDR_IRQ_MSK) begin
                irq_msk_q <= hwdata[CH-1:0];
            end
        end
    end

    // ************
    // interrupt status: sticky, cleared by reading it
    // ************
    // a new event in the clearing cycle survives the clear
    assign st_clr = (rd_go && st_read) ? irq_st_q : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~st_clr) | cirq_ev; // [RQ14]
        end
    end

    assign irq = |(irq_st_q & irq_msk_q);

    // ************
    // input synchronisers and edge detection
    // ************
    // order: channel pins, then the two count inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            stable_q <= '0;
        end else begin
            s1_q <= {count_in, cc_pin_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < SYNC_N; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_q[i] <= s3_q[i];
                end
            end
        end
    end

    // a change counts only once the last two stages agree
    assign rise = (s2_q ~^ s3_q) & s3_q & ~stable_q;
    assign fall = (s2_q ~^ s3_q) & ~s3_q & stable_q;

    // ************
    // prescaler
    // ************
    // staggered operation slows the base rate to one step in eight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_q <= '0;
        end else begin
            psc_q <= psc_q + 1'b1;
        end
    end

    assign base_en = !stagger_q || (psc_q[2:0] == STAG_SLOTS_M1); // [RQ1]
    assign psc_eff = stagger_q ? psc_q[10:3] : psc_q[7:0];

    // ************
    // time bases: timers 0,1 in array a, 2,3 in array b
    // ************
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
        logic [7:0] mask;
        logic       psc_hit;
        logic       wr_cfg;
        logic       wr_val;
        logic       wr_rld;

        assign mask    = 8'(({1'b0, 8'hff}) >> (4'd8 - {1'b0, tcfg_q[t].psc}));
        assign psc_hit = base_en && ((psc_eff & mask) == 8'h00);
        assign wr_cfg  = wr_pend_q && (wr_addr_q == ADDR_TCFG + 12'(4 * t));
        assign wr_val  = wr_pend_q && (wr_addr_q == ADDR_TVAL + 12'(4 * t));
        assign wr_rld  = wr_pend_q && (wr_addr_q == ADDR_TRLD + 12'(4 * t));

        // clock source selection per timer [RQ3]
        always_comb begin
            tstep[t] = 1'b0;
            if (tcfg_q[t].run) begin
                unique case (tcfg_q[t].src)
                    SRC_PRESCALE: tstep[t] = psc_hit;
                    SRC_EXT_OVF:  tstep[t] = ext_gp_ovf;
                    // only the first timer of an array has a count input
                    SRC_COUNT_IN: tstep[t] = (t % 2 == 0) &&
                                             rise[CH + t / 2]; // [RQ4]
                    default:      tstep[t] = 1'b0;
                endcase
            end
        end

        // configuration and reload registers [RQ2]
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tcfg_q[t] <= '0;
                trld_q[t] <= TMR_RST;
            end else begin
                if (wr_cfg) begin
                    tcfg_q[t].psc <= hwdata[TCFG_PSC_LSB +: 3];
                    tcfg_q[t].src <= hwdata[TCFG_SRC_LSB +: 2];
                    tcfg_q[t].run <= hwdata[TCFG_RUN_BIT];
                end
                if (wr_rld) begin
                    trld_q[t] <= hwdata[TMR_W-1:0];
                end
            end
        end

        // count up, reload on overflow; a software write takes priority
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tval_q[t]    <= TMR_RST;
                tstrobe_q[t] <= 1'b0;
                tovf_q[t]    <= 1'b0;
            end else begin
                tstrobe_q[t] <= tstep[t] && !wr_val;
                tovf_q[t]    <= tstep[t] && !wr_val && (tval_q[t] == TMR_MAX);
                if (wr_val) begin
                    tval_q[t] <= hwdata[TMR_W-1:0];
                end else if (tstep[t]) begin
                    if (tval_q[t] == TMR_MAX) begin
                        tval_q[t] <= trld_q[t]; // [RQ17]
                    end else begin
                        tval_q[t] <= tval_q[t] + 1'b1;
                    end
                end
            end
        end
    end

    // ************
    // channels: 0..15 in array a, 16..31 in array b
    // ************
    for (genvar c = 0; c < CH; c++) begin : g_ch
        localparam int ARR  = c / 16;
        localparam int PART = c ^ 8;
        logic        wr_ccfg;
        logic        wr_cval;
        dacc_tbase_t tb;
        logic        tsel_idx;

        assign wr_ccfg  = wr_pend_q && (wr_addr_q == ADDR_CCFG + 12'(4 * c));
        assign wr_cval  = wr_pend_q && (wr_addr_q == ADDR_CVAL + 12'(4 * c));
        // each register picks one of its own array's two timers [RQ5]
        assign tsel_idx = ccfg_q[c].tsel;
        assign tb.value = tval_q[2 * ARR + int'(tsel_idx)];
        assign tb.strobe = tstrobe_q[2 * ARR + int'(tsel_idx)];
        assign tb.ovf   = tovf_q[2 * ARR + int'(tsel_idx)];

        // mode, timer choice and options per register [RQ5]
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ccfg_q[c] <= '0;
            end else if (wr_ccfg) begin
                ccfg_q[c].mode   <= dacc_mode_t'(hwdata[CCFG_MODE_LSB +: 3]);
                ccfg_q[c].tsel   <= hwdata[CCFG_TSEL_BIT];
                ccfg_q[c].single <= hwdata[CCFG_SINGLE_BIT];
                ccfg_q[c].dbl    <= hwdata[CCFG_DOUBLE_BIT];
            end
        end

        // partner is the register eight places away in the same array
        dacc_channel u_ch (
            .hclk          (hclk),
            .hresetn       (hresetn),
            .cfg           (ccfg_q[c]),
            .cfg_wr        (wr_ccfg),
            .val_wr        (wr_cval),
            .wdata         (hwdata[TMR_W-1:0]),
            .tb            (tb),
            .pin_rise      (rise[c]),
            .pin_fall      (fall[c]),
            .partner_match (cmatch[PART]), // [RQ11]
            .val_q         (cval[c]),
            .pin_out_q     (cc_pin_out[c]),
            .pin_oe        (cc_pin_oe[c]),
            .match         (cmatch[c]),
            .irq_ev        (cirq_ev[c])
        );
    end

endmodule
